// [src/host_port_pkg.sv]
package host_port_pkg;
	localparam int NUM_CHAN = 4;
	localparam int NUM_IRQ  = 5;
	localparam int NUM_MUX  = 3;
	// register byte addresses on the cpu port
	localparam logic [15:0] HOST_IF_CTRL_OFS = 16'hfff0;
	localparam logic [15:0] SYS_CTRL2_OFS    = 16'hfff4;
	localparam logic [15:0] AUX_CTRL_OFS     = 16'hfff5;
	localparam logic [15:0] PIN_DIR_OFS      = 16'hfff6;
	localparam logic [15:0] IRQ_LATCH_OFS    = 16'hfff7;
	localparam logic [15:0] ODR_BASE_OFS     = 16'hfe00;
	localparam logic [15:0] IDR_BASE_OFS     = 16'hfe04;
	localparam logic [15:0] STR_BASE_OFS     = 16'hfe08;
	// field positions
	localparam int FAST_GATE_EN_BIT = 0;
	localparam int HOST_PORT_EN_BIT = 0;
	localparam int SHUTDOWN_EN_BIT  = 1;
	localparam int CHAN2_EN_BIT     = 2;
	localparam int CHAN3_EN_BIT     = 3;
	localparam int CHAN4_EN_BIT     = 4;
	localparam int GATE_STAT_BIT    = 0;
	localparam int GATE_DIR_BIT     = 5;
	localparam int STR_OBF_BIT      = 0;
	localparam int STR_IBF_BIT      = 1;
	localparam int STR_CMD_BIT      = 3;
	localparam int GATE_DATA_BIT    = 1;
	// reset values
	localparam logic [7:0] HOST_IF_CTRL_RST = 8'h00;
	localparam logic [7:0] SYS_CTRL2_RST    = 8'h00;
	localparam logic [7:0] PIN_DIR_RST      = 8'h00;
	localparam logic [7:0] IRQ_LATCH_RST    = 8'h00;
	localparam logic       GATE_RST         = 1'b1;
	// gate command codes
	localparam logic [7:0] GATE_CMD     = 8'hd1;
	localparam logic [7:0] GATE_END_CMD = 8'hff;

	typedef enum logic [1:0] {
		GATE_IDLE,
		GATE_ARMED,
		GATE_DONE
	} gate_state_t;
endpackage : host_port_pkg

// [src/host_parallel_port_gate_ctl.sv]
`timescale 1ns/100ps
// Overview of operation
// - read, address 0: drive output data
// - read, address 1: drive status register
// - write, address 0: capture data byte
// - write, address 1: capture command byte
// - command/data flag follows address at write
// - port works only when enabled
// - fast gate needs fast-gate enable bit
// - gate pin level readable in status
// - gate output starts at one
// - decoder watches channel 1 only
// - data bit1 one after D1 sets gate
// - data bit1 zero after D1 clears gate
// - clearing fast-gate enable clears gate
// - D1, data, FF leave flag clear
// - other command after sequence sets flag
// - non-D1 cancels; repeated D1 re-arms
// - shutdown needs shutdown and port enable
// - shutdown floats irq and gate outputs
// - shutdown forces selects, strobes, address high
// - shutdown floats host data bus
// - shutdown release restores normal operation
// - shutdown freezes shared muxed inputs
// - optional pins shut only when selected
// - channel 2 select pin follows fast-gate
module host_parallel_port_gate_ctl
	import host_port_pkg::*;
(
	input  wire logic                i_core_clk,
	input  wire logic                i_rst,
	input  wire logic [15:0]         i_reg_addr,
	input  wire logic [7:0]          i_reg_wdata,
	input  wire logic                i_reg_wr,
	input  wire logic                i_reg_rd,
	output logic      [7:0]          o_reg_rdata,
	input  wire logic                i_chan1_select_n,
	input  wire logic                i_chan2_select_n,
	input  wire logic                i_chan2_alt_select_n,
	input  wire logic                i_chan3_select_n,
	input  wire logic                i_chan4_select_n,
	input  wire logic                i_host_addr_bit,
	input  wire logic                i_host_rd_n,
	input  wire logic                i_host_wr_n,
	input  wire logic [7:0]          i_host_data_bus,
	output logic      [7:0]          o_host_data_bus,
	output logic                     o_host_data_oe_n,
	output logic                     o_gate_out,
	output logic                     o_gate_oe_n,
	output logic      [NUM_IRQ-1:0]  o_host_irq,
	output logic      [NUM_IRQ-1:0]  o_host_irq_oe_n,
	input  wire logic                i_port_shutdown_n,
	input  wire logic [NUM_MUX-1:0]  i_mux_in,
	output logic      [NUM_MUX-1:0]  o_mux_in,
	output logic                     o_chan1_in_full_irq
);
	// true when the address falls in a four-channel register bank
	function automatic logic bank_hit(input logic [15:0] a, input logic [15:0] base);
		bank_hit = (a[15:2] == base[15:2]);
	endfunction : bank_hit
	function automatic logic [1:0] onehot_idx(input logic [NUM_CHAN-1:0] v);
		onehot_idx = v[3] ? 2'd3 : v[2] ? 2'd2 : v[1] ? 2'd1 : 2'd0;
	endfunction : onehot_idx
	logic [7:0]                  host_interface_control_ff, sys_ff, dir_ff, irq_ff, rdata_ff, nxt_rdata;
	logic [4:0]                  sel_meta_ff, sel_sync_ff;
	logic [3:0]                  ctl_meta_ff, ctl_sync_ff;
	logic [7:0]                  dat_meta_ff, dat_sync_ff;
	logic [NUM_MUX-1:0]          mux_meta_ff, mux_sync_ff, mux_ff, mux_frz;
	logic [NUM_CHAN-1:0][7:0]    idr_ff, odr_ff, str_val;
	logic [NUM_CHAN-1:0]         ibf_ff, obf_ff, cd_ff, ibf_set, ibf_clr, obf_set, obf_clr;
	logic [NUM_CHAN-1:0]         chan_en, sel_raw, sel_act;
	logic                        wr_acc_ff, wr_addr_ff, rd_acc_ff, rd_addr_ff;
	logic [1:0]                  wr_ch_ff, rd_ch_ff;
	logic [7:0]                  wr_data_ff, hdata_ff;
	logic                        hoe_n_ff, gate_ff, nxt_gate, swallow;
	gate_state_t                 gate_st_ff, nxt_gate_st;
	wire hpe   = sys_ff[HOST_PORT_EN_BIT];
	wire fen   = host_interface_control_ff[FAST_GATE_EN_BIT];
	wire c2en  = sys_ff[CHAN2_EN_BIT];
	wire sd_sync = ctl_sync_ff[3];
	// shutdown pin only counts with both enables
	wire sd_active = hpe & sys_ff[SHUTDOWN_EN_BIT] & ~sd_sync;
	// every host pin passes two flops before use; async to our clock
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sel_meta_ff <= 5'h1f;
			sel_sync_ff <= 5'h1f;
			ctl_meta_ff <= 4'hf;
			ctl_sync_ff <= 4'hf;
			dat_meta_ff <= 8'h00;
			dat_sync_ff <= 8'h00;
			mux_meta_ff <= 3'h0;
			mux_sync_ff <= 3'h0;
		end else begin
			sel_meta_ff <= {i_chan4_select_n, i_chan3_select_n, i_chan2_alt_select_n,
				i_chan2_select_n, i_chan1_select_n};
			sel_sync_ff <= sel_meta_ff;
			ctl_meta_ff <= {i_port_shutdown_n, i_host_addr_bit, i_host_wr_n, i_host_rd_n};
			ctl_sync_ff <= ctl_meta_ff;
			dat_meta_ff <= i_host_data_bus;
			dat_sync_ff <= dat_meta_ff;
			mux_meta_ff <= i_mux_in;
			mux_sync_ff <= mux_meta_ff;
		end
	end
	// channels only live while the port is enabled
	assign chan_en = {sys_ff[CHAN4_EN_BIT], sys_ff[CHAN3_EN_BIT], c2en, 1'b1} & {4{hpe}};
	// fast gate takes the primary pin, so channel 2 moves to the alternate
	assign sel_raw = {sel_sync_ff[4], sel_sync_ff[3],
		fen ? sel_sync_ff[2] : sel_sync_ff[1], sel_sync_ff[0]};
	// shutdown forces every select, strobe and address high internally
	assign sel_act = ~sel_raw & chan_en & {4{~sd_active}};
	wire rd_low   = ~ctl_sync_ff[0] & ~sd_active;
	wire wr_low   = ~ctl_sync_ff[1] & ~sd_active;
	wire addr_eff = ctl_sync_ff[2] | sd_active;
	// two selects at once is contention on the pins; treat as idle
	wire one_sel  = (sel_act != 4'h0) && ((sel_act & (sel_act - 4'd1)) == 4'h0);
	// both strobes high or both low: no access at all
	wire rd_acc   = one_sel & rd_low & ~wr_low;
	wire wr_acc   = one_sel & wr_low & ~rd_low;
	wire [1:0] acc_ch = onehot_idx(sel_act);
	wire wr_commit = wr_acc_ff & ~wr_acc;
	wire rd_done   = rd_acc_ff & ~rd_acc;
	// hold the last address and data seen while the write strobe is low
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			wr_acc_ff  <= 1'b0;
			wr_addr_ff <= 1'b0;
			wr_ch_ff   <= 2'd0;
			wr_data_ff <= 8'h00;
			rd_acc_ff  <= 1'b0;
			rd_addr_ff <= 1'b0;
			rd_ch_ff   <= 2'd0;
		end else begin
			wr_acc_ff <= wr_acc;
			rd_acc_ff <= rd_acc;
			if (wr_acc) begin
				wr_addr_ff <= addr_eff;
				wr_ch_ff   <= acc_ch;
				wr_data_ff <= dat_sync_ff;
			end
			if (rd_acc) begin
				rd_addr_ff <= addr_eff;
				rd_ch_ff   <= acc_ch;
			end
		end
	end
	// data or status onto the bus; oe released when no read
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			hdata_ff <= 8'h00;
			hoe_n_ff <= 1'b1;
		end else begin
			hdata_ff <= addr_eff ? str_val[acc_ch] : odr_ff[acc_ch];
			hoe_n_ff <= ~rd_acc;
		end
	end
	assign o_host_data_bus  = hdata_ff;
	assign o_host_data_oe_n = hoe_n_ff;
	// cpu-side strobes
	wire cpu_odr_wr = i_reg_wr & bank_hit(i_reg_addr, ODR_BASE_OFS);
	wire cpu_idr_rd = i_reg_rd & bank_hit(i_reg_addr, IDR_BASE_OFS);
	wire host_interface_control_wr    = i_reg_wr & (i_reg_addr == HOST_IF_CTRL_OFS);
	wire fen_clr    = host_interface_control_wr & ~i_reg_wdata[FAST_GATE_EN_BIT];
	// decoder sees only channel 1 writes, and only in fast mode
	wire gate_hit   = wr_commit & fen & (wr_ch_ff == 2'd0);
	wire is_d1      = wr_addr_ff & (wr_data_ff == GATE_CMD);
	wire is_ff      = wr_addr_ff & (wr_data_ff == GATE_END_CMD);
	// gate sequence decoder, runs only with fast gate enabled
	always_comb begin
		nxt_gate_st = gate_st_ff;
		nxt_gate    = gate_ff;
		swallow     = 1'b0;
		case (gate_st_ff)
			GATE_IDLE: begin
				if (is_d1) begin
					nxt_gate_st = GATE_ARMED;
					swallow     = 1'b1;
				end
			end
			GATE_ARMED: begin
				// repeated D1 re-arms, other command cancels
				if (is_d1) begin
					swallow = 1'b1;
				end else if (wr_addr_ff) begin
					nxt_gate_st = GATE_IDLE;
				end else begin
					// bit 1 of the data byte goes to the pin
					nxt_gate    = wr_data_ff[GATE_DATA_BIT];
					nxt_gate_st = GATE_DONE;
					swallow     = 1'b1;
				end
			end
			GATE_DONE: begin
				// trailing FF and a new D1 are absorbed; other bytes reach firmware
				swallow = is_d1 | is_ff;
				nxt_gate_st = is_d1 ? GATE_ARMED : GATE_IDLE;
			end
			default: begin
				nxt_gate_st = GATE_IDLE;
			end
		endcase
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			gate_ff    <= GATE_RST;
			gate_st_ff <= GATE_IDLE;
		end else if (fen_clr) begin
			gate_ff    <= 1'b0;
			gate_st_ff <= GATE_IDLE;
		end else if (gate_hit) begin
			gate_ff    <= nxt_gate;
			gate_st_ff <= nxt_gate_st;
		end
	end
	// per-channel flag events; a set always beats a clear in the same cycle
	for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
		// regular mode flags every write; fast mode hides gate bytes
		assign ibf_set[g] = wr_commit & (wr_ch_ff == g) & ~((g == 0) & gate_hit & swallow);
		assign ibf_clr[g] = cpu_idr_rd & (i_reg_addr[1:0] == g);
		assign obf_set[g] = cpu_odr_wr & (i_reg_addr[1:0] == g);
		assign obf_clr[g] = rd_done & ~rd_addr_ff & (rd_ch_ff == g);
		assign str_val[g] = {4'h0, cd_ff[g], 1'b0, ibf_ff[g], obf_ff[g]};
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			idr_ff <= '0;
			odr_ff <= '0;
			ibf_ff <= '0;
			obf_ff <= '0;
			cd_ff  <= '0;
		end else begin
			ibf_ff <= ibf_set | (ibf_ff & ~ibf_clr);
			obf_ff <= obf_set | (obf_ff & ~obf_clr);
			for (int i = 0; i < NUM_CHAN; i++) begin
				// byte lands in the input register, flag tracks address
				if (wr_commit && wr_ch_ff == i) begin
					idr_ff[i] <= wr_data_ff;
					cd_ff[i]  <= wr_addr_ff;
				end
				if (obf_set[i]) begin
					odr_ff[i] <= i_reg_wdata;
				end
			end
		end
	end
	assign o_chan1_in_full_irq = ibf_ff[0];
	// cpu control registers
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			host_interface_control_ff <= HOST_IF_CTRL_RST;
			sys_ff  <= SYS_CTRL2_RST;
			dir_ff  <= PIN_DIR_RST;
			irq_ff  <= IRQ_LATCH_RST;
		end else if (i_reg_wr) begin
			if (host_interface_control_wr) begin
				host_interface_control_ff <= i_reg_wdata;
			end else if (i_reg_addr == SYS_CTRL2_OFS) begin
				sys_ff <= i_reg_wdata;
			end else if (i_reg_addr == PIN_DIR_OFS) begin
				dir_ff <= i_reg_wdata;
			end else if (i_reg_addr == IRQ_LATCH_OFS) begin
				irq_ff <= i_reg_wdata;
			end
		end
	end
	// read mux; unmapped addresses read zero
	always_comb begin
		nxt_rdata = 8'h00;
		if (i_reg_addr == HOST_IF_CTRL_OFS) begin
			nxt_rdata = host_interface_control_ff;
		end else if (i_reg_addr == SYS_CTRL2_OFS) begin
			nxt_rdata = sys_ff;
		end else if (i_reg_addr == AUX_CTRL_OFS) begin
			// pin level, since the port bit no longer reflects it
			nxt_rdata[GATE_STAT_BIT] = gate_ff;
		end else if (i_reg_addr == PIN_DIR_OFS) begin
			nxt_rdata = dir_ff;
		end else if (i_reg_addr == IRQ_LATCH_OFS) begin
			nxt_rdata = irq_ff;
		end else if (bank_hit(i_reg_addr, ODR_BASE_OFS)) begin
			nxt_rdata = odr_ff[i_reg_addr[1:0]];
		end else if (bank_hit(i_reg_addr, IDR_BASE_OFS)) begin
			nxt_rdata = idr_ff[i_reg_addr[1:0]];
		end else if (bank_hit(i_reg_addr, STR_BASE_OFS)) begin
			nxt_rdata = str_val[i_reg_addr[1:0]];
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			rdata_ff <= 8'h00;
		end else if (i_reg_rd) begin
			rdata_ff <= nxt_rdata;
		end
	end
	assign o_reg_rdata = rdata_ff;
	// optional pins are only ours when selected by the registers
	wire [NUM_IRQ-1:0] irq_sel = {hpe & sys_ff[CHAN4_EN_BIT] & dir_ff[4],
		hpe & sys_ff[CHAN3_EN_BIT] & dir_ff[3], hpe & dir_ff[2],
		hpe & c2en & dir_ff[1], hpe & dir_ff[0]};
	// outputs float while shutdown holds or while their pin is not selected
	assign o_host_irq      = irq_ff[NUM_IRQ-1:0];
	assign o_host_irq_oe_n = ~(irq_sel & {NUM_IRQ{~sd_active}});
	assign o_gate_out      = gate_ff;
	assign o_gate_oe_n     = ~(hpe & fen & dir_ff[GATE_DIR_BIT] & ~sd_active);
	// shared inputs hold their last value while their pin is shut
	assign mux_frz = {sd_active & irq_sel[2], sd_active & irq_sel[1], sd_active & c2en & fen};
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			mux_ff <= 3'h0;
		end else begin
			mux_ff <= (mux_ff & mux_frz) | (mux_sync_ff & ~mux_frz);
		end
	end
	assign o_mux_in = mux_ff;
	// checks on the host side and the gate decoder
	AST_RD_ODR: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rd_acc && !addr_eff |=> !o_host_data_oe_n && o_host_data_bus == $past(odr_ff[acc_ch]))
		else $error("odr not driven on host read");
	AST_RD_STR: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rd_acc && addr_eff |=> o_host_data_bus == $past(str_val[acc_ch]))
		else $error("status not driven on host read");
	AST_WR_IDR: assert property (@(posedge i_core_clk) disable iff (i_rst)
		wr_commit |=> idr_ff[$past(wr_ch_ff)] == $past(wr_data_ff))
		else $error("input register missed host byte");
	AST_CMD_FLAG: assert property (@(posedge i_core_clk) disable iff (i_rst)
		wr_commit |=> cd_ff[$past(wr_ch_ff)] == $past(wr_addr_ff))
		else $error("command flag wrong after write");
	AST_NO_BOTH: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(rd_low && wr_low) || !hpe |=> !wr_acc_ff && o_host_data_oe_n)
		else $error("access with both strobes or port off");
	AST_GATE_RST: assert property (@(posedge i_core_clk)
		$past(i_rst) && !i_rst |-> o_gate_out)
		else $error("gate not high after reset");
	AST_GATE_DATA: assert property (@(posedge i_core_clk) disable iff (i_rst)
		gate_hit && gate_st_ff == GATE_ARMED && !wr_addr_ff && !fen_clr
		|=> o_gate_out == $past(wr_data_ff[GATE_DATA_BIT])
		##1 ($past(fen_clr) || o_gate_out == $past(o_gate_out)))
		else $error("gate output does not follow data bit");
	AST_GATE_OFF: assert property (@(posedge i_core_clk) disable iff (i_rst)
		fen_clr |=> !o_gate_out)
		else $error("gate not cleared with enable");
	AST_D1_QUIET: assert property (@(posedge i_core_clk) disable iff (i_rst)
		gate_hit && is_d1 |-> !ibf_set[0])
		else $error("D1 command flagged to firmware");
	AST_CANCEL: assert property (@(posedge i_core_clk) disable iff (i_rst)
		gate_hit && gate_st_ff == GATE_ARMED && wr_addr_ff && !is_d1 && !fen_clr
		|-> ibf_set[0] ##1 gate_st_ff == GATE_IDLE)
		else $error("cancelled sequence not flagged");
	AST_SD_FLOAT: assert property (@(posedge i_core_clk) disable iff (i_rst)
		sd_active |-> &o_host_irq_oe_n && o_gate_oe_n && !rd_acc && !wr_acc)
		else $error("outputs driven during shutdown");
	AST_SD_BUS: assert property (@(posedge i_core_clk) disable iff (i_rst)
		sd_active [*2] |-> o_host_data_oe_n)
		else $error("data bus driven during shutdown");
	CVR_GATE_SET: cover property (@(posedge i_core_clk) disable iff (i_rst)
		gate_hit && gate_st_ff == GATE_ARMED && !wr_addr_ff);
	CVR_CANCEL: cover property (@(posedge i_core_clk) disable iff (i_rst)
		gate_hit && gate_st_ff == GATE_ARMED && wr_addr_ff && !is_d1);
	CVR_SHUTDOWN: cover property (@(posedge i_core_clk) disable iff (i_rst)
		sd_active ##1 !sd_active);
	CVR_STR_READ: cover property (@(posedge i_core_clk) disable iff (i_rst)
		rd_done && rd_addr_ff);
endmodule : host_parallel_port_gate_ctl

// [verif/host_model.sv]
`timescale 1ns/100ps
// host processor on the parallel port, paced by the core clock for simplicity
module host_model (
	input  wire logic       i_core_clk,
	output logic      [4:0] o_sel_n,
	output logic            o_addr,
	output logic            o_rd_n,
	output logic            o_wr_n,
	output logic      [7:0] o_data,
	input  wire logic [7:0] i_data,
	input  wire logic       i_oe_n
);
	// selects: bits 0..3 channels 1..4, bit 4 the alternate channel 2 select
	initial begin
		o_sel_n = 5'h1f;
		o_addr  = 1'b0;
		o_rd_n  = 1'b1;
		o_wr_n  = 1'b1;
		o_data  = 8'h00;
	end

	// released lines show the inverse, never a stale copy of the last byte
	task automatic release_bus();
		@(posedge i_core_clk);
		o_sel_n <= 5'h1f;
		o_data  <= ~o_data;
		o_addr  <= ~o_addr;
		repeat (6) @(posedge i_core_clk);
	endtask : release_bus

	task automatic wr(input logic [4:0] sel, input logic a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_sel_n <= sel;
		o_addr  <= a;
		o_data  <= d;
		o_wr_n  <= 1'b0;
		// strobe held well past the synchroniser depth
		repeat (5) @(posedge i_core_clk);
		o_wr_n <= 1'b1;
		@(posedge i_core_clk);
		release_bus();
	endtask : wr

	task automatic rd(input logic [4:0] sel, input logic a, output logic [7:0] d,
			output logic oe_n);
		@(posedge i_core_clk);
		o_sel_n <= sel;
		o_addr  <= a;
		o_rd_n  <= 1'b0;
		// answer is due three cycles after the pins change
		repeat (5) @(posedge i_core_clk);
		d = i_data;
		oe_n = i_oe_n;
		o_rd_n <= 1'b1;
		@(posedge i_core_clk);
		release_bus();
	endtask : rd
endmodule : host_model

// [verif/tb.sv]
`timescale 1ns/100ps
module tb;
	import host_port_pkg::*;
	logic               i_core_clk;
	logic               i_rst;
	logic        [15:0] i_reg_addr;
	logic         [7:0] i_reg_wdata;
	logic               i_reg_wr;
	logic               i_reg_rd;
	logic         [7:0] o_reg_rdata;
	logic         [4:0] sel_n;
	logic               haddr;
	logic               hrd_n;
	logic               hwr_n;
	logic         [7:0] hdata;
	logic         [7:0] dut_data;
	logic         [7:0] bus;
	logic               data_oe_n;
	logic               gate_out;
	logic               gate_oe_n;
	logic [NUM_IRQ-1:0] irq;
	logic [NUM_IRQ-1:0] irq_oe_n;
	logic               shut_n;
	logic [NUM_MUX-1:0] mux_in;
	logic [NUM_MUX-1:0] mux_out;
	logic               full_irq;
	logic         [7:0] hd;
	logic               oe;
	int                 miscompares;
	int                 compares;
	// fast gate walk: {addr, byte, gate after, channel 1 status after}
	logic        [31:0] gate_steps [10] = '{32'h01d10108, 32'h00000000, 32'h01ff0008,
		32'h01d10008, 32'h00020100, 32'h0155010a, 32'h01d10108, 32'h01d10108,
		32'h0120010a, 32'h00000102};

	// the device wins the data bus while it drives, else the host's level
	assign bus = data_oe_n ? hdata : dut_data;

	host_parallel_port_gate_ctl DUT (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_chan1_select_n(sel_n[0]),
		.i_chan2_select_n(sel_n[1]), .i_chan2_alt_select_n(sel_n[4]),
		.i_chan3_select_n(sel_n[2]), .i_chan4_select_n(sel_n[3]),
		.i_host_addr_bit(haddr), .i_host_rd_n(hrd_n), .i_host_wr_n(hwr_n),
		.i_host_data_bus(bus), .o_host_data_bus(dut_data), .o_host_data_oe_n(data_oe_n),
		.o_gate_out(gate_out), .o_gate_oe_n(gate_oe_n), .o_host_irq(irq),
		.o_host_irq_oe_n(irq_oe_n), .i_port_shutdown_n(shut_n), .i_mux_in(mux_in),
		.o_mux_in(mux_out), .o_chan1_in_full_irq(full_irq));

	host_model u_host (.i_core_clk(i_core_clk), .o_sel_n(sel_n), .o_addr(haddr),
		.o_rd_n(hrd_n), .o_wr_n(hwr_n), .o_data(hdata), .i_data(bus), .i_oe_n(data_oe_n));

	// 100 MHz core clock
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_reg_wr    <= 1'b1;
		i_reg_addr  <= a;
		i_reg_wdata <= d;
		@(posedge i_core_clk);
		i_reg_wr <= 1'b0;
	endtask : reg_wr

	// read data stand from the cycle after the strobe until the next read
	task automatic reg_chk(input logic [15:0] a, input logic [7:0] exp, input string msg);
		@(posedge i_core_clk);
		i_reg_rd   <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_core_clk);
		i_reg_rd <= 1'b0;
		@(posedge i_core_clk);
		check(o_reg_rdata, exp, msg);
	endtask : reg_chk

	task automatic end_sim();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge i_core_clk);
		miscompares++;
		end_sim();
	end

	initial begin
		i_rst = 1'b1;
		i_reg_addr = 16'h0000;
		i_reg_wdata = 8'h00;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		shut_n = 1'b1;
		mux_in = 3'h0;
		miscompares = 0;
		compares = 0;
		repeat (20) @(posedge i_core_clk);
		i_rst <= 1'b0;
		reg_chk(HOST_IF_CTRL_OFS, HOST_IF_CTRL_RST, "ctrl reset");
		reg_chk(SYS_CTRL2_OFS, SYS_CTRL2_RST, "sys reset");
		reg_chk(AUX_CTRL_OFS, 8'h01, "gate status reset");
		reg_chk(16'h0000, 8'h00, "unmapped read");
		check({7'h0, gate_out}, 8'h01, "gate pin reset");
		// host access while the port is off must leave no trace
		u_host.wr(5'h1e, 1'b0, 8'h5a);
		reg_chk(STR_BASE_OFS, 8'h00, "disabled port took write");
		reg_wr(16'h0000, 8'hff);
		reg_wr(SYS_CTRL2_OFS, 8'h1d);
		reg_chk(SYS_CTRL2_OFS, 8'h1d, "sys ctrl write");
		// every channel: write, then both reads; channels 2 and 4 send commands
		for (int ch = 0; ch < 4; ch++) begin
			u_host.wr(~(5'h01 << ch), ch[0], 8'h10 + 8'(ch));
			reg_chk(STR_BASE_OFS + 16'(ch), {4'h0, ch[0], 3'b010}, "status after write");
			reg_chk(IDR_BASE_OFS + 16'(ch), 8'h10 + 8'(ch), "input data");
			reg_wr(ODR_BASE_OFS + 16'(ch), 8'ha0 + 8'(ch));
			u_host.rd(~(5'h01 << ch), 1'b1, hd, oe);
			check(hd, {4'h0, ch[0], 3'b001}, "host status read");
			u_host.rd(~(5'h01 << ch), 1'b0, hd, oe);
			check(hd, 8'ha0 + 8'(ch), "host data read");
			check({7'h0, oe}, 8'h00, "data bus not driven on read");
			reg_chk(STR_BASE_OFS + 16'(ch), {4'h0, ch[0], 3'b000}, "flags after reads");
		end
		reg_wr(PIN_DIR_OFS, 8'h20);
		reg_wr(HOST_IF_CTRL_OFS, 8'h01);
		@(posedge i_core_clk);
		check({7'h0, gate_oe_n}, 8'h00, "gate pin not driven");
		// shutdown pin alone does nothing while shutdown is not enabled
		shut_n <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		check({7'h0, gate_oe_n}, 8'h00, "shutdown acted while disabled");
		shut_n <= 1'b1;
		foreach (gate_steps[i]) begin
			u_host.wr(5'h1e, gate_steps[i][24], gate_steps[i][23:16]);
			check({7'h0, gate_out}, gate_steps[i][15:8], "gate level");
			reg_chk(AUX_CTRL_OFS, gate_steps[i][15:8], "gate status bit");
			reg_chk(STR_BASE_OFS, gate_steps[i][7:0], "gate flags");
			reg_chk(IDR_BASE_OFS, gate_steps[i][23:16], "gate byte stored");
		end
		// decoder must ignore a gate sequence on channel 3
		u_host.wr(5'h1b, 1'b1, GATE_CMD);
		u_host.wr(5'h1b, 1'b0, 8'h00);
		check({7'h0, gate_out}, 8'h01, "gate moved by channel 3");
		reg_chk(STR_BASE_OFS + 16'h2, 8'h02, "channel 3 flags");
		// channel 2 select moves to the alternate pin
		u_host.wr(5'h1d, 1'b0, 8'h66);
		reg_chk(IDR_BASE_OFS + 16'h1, 8'h11, "primary select still live");
		u_host.wr(5'h0f, 1'b0, 8'h77);
		reg_chk(IDR_BASE_OFS + 16'h1, 8'h77, "alternate select dead");
		reg_wr(HOST_IF_CTRL_OFS, 8'h00);
		reg_chk(AUX_CTRL_OFS, 8'h00, "gate not cleared");
		check({7'h0, gate_oe_n}, 8'h01, "gate pin kept");
		u_host.wr(5'h1e, 1'b1, GATE_CMD);
		reg_chk(STR_BASE_OFS, 8'h0a, "regular mode flag");
		check({7'h0, full_irq}, 8'h01, "channel 1 full");
		reg_wr(SYS_CTRL2_OFS, 8'h1f);
		reg_wr(HOST_IF_CTRL_OFS, 8'h01);
		reg_wr(PIN_DIR_OFS, 8'h3f);
		reg_wr(IRQ_LATCH_OFS, 8'h15);
		mux_in <= 3'h7;
		repeat (5) @(posedge i_core_clk);
		check({3'h0, irq}, 8'h15, "irq levels");
		check({3'h0, irq_oe_n}, 8'h00, "irq pins not driven");
		check({5'h0, mux_out}, 8'h07, "shared inputs");
		shut_n <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		mux_in <= 3'h0;
		check({3'h0, irq_oe_n}, 8'h1f, "irq pins driven in shutdown");
		check({7'h0, gate_oe_n}, 8'h01, "gate driven in shutdown");
		u_host.wr(5'h1e, 1'b0, 8'h99);
		u_host.rd(5'h1e, 1'b0, hd, oe);
		check({7'h0, oe}, 8'h01, "data bus driven in shutdown");
		check({5'h0, mux_out}, 8'h07, "shared inputs not frozen");
		reg_chk(IDR_BASE_OFS, GATE_CMD, "write taken in shutdown");
		shut_n <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		check({3'h0, irq_oe_n}, 8'h00, "irq pins not restored");
		check({5'h0, mux_out}, 8'h00, "shared inputs still frozen");
		u_host.wr(5'h1e, 1'b0, 8'h3c);
		reg_chk(IDR_BASE_OFS, 8'h3c, "port not restored");
		end_sim();
	end
endmodule : tb
